// file: src/pac_classifier.sv
/*
 * Ingress rule_list classifier: walks an ordered list of match_entry records for each
 * parsed header and gives a permit, deny or shutdown verdict, with an APB register port.
 * It assumes the forwarding pipeline on the same clock holds a header until taken.
 */
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "pac_consts.svh"

// Function
// - Entries are checked one per cycle in list order.
// - The first entry that hits decides; later entries are skipped.
// - Permit hit forwards the packet.
// - Deny hit drops the packet.
// - Shutdown hit drops the packet and disables its port.
// - Protocol matches any value or one configured 8-bit number.
// - Each TCP flag is required set, required clear, or ignored.
// - Layer-4 ports count only when the entry protocol is TCP or UDP.
// - Source IP mask bit one ignores, zero compares.
// - Only unmasked source address bits take part in the compare.
// - Destination IP compares under its own wildcard mask.
// - An entry matches DSCP or precedence, never both.
// - Source and destination MAC compare each under own wildcard mask.
// - VLAN criterion equals a configured value from 2 to 4094.
// - Ethernet type criterion equals a configured 16-bit value.
// - Bound list drops packets matching no entry.
module pac_classifier #(
    parameter int NENT   = 8,
    parameter int NPORTS = 8,
    parameter int PW     = 3
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire pac_pkg::pac_word_t pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              pktValid,
    output logic                   pktReady,
    input  wire logic [PW-1:0]     pktPort,
    input  wire logic              pktIsIp,
    input  wire logic [7:0]        pktProto,
    input  wire logic [5:0]        pktTcpFlags,
    input  wire logic [15:0]       pktSrcPort,
    input  wire logic [15:0]       pktDstPort,
    input  wire logic [31:0]       pktSrcIp,
    input  wire logic [31:0]       pktDstIp,
    input  wire logic [5:0]        pktDscp,
    input  wire logic [47:0]       pktSrcMac,
    input  wire logic [47:0]       pktDstMac,
    input  wire logic [11:0]       pktVlan,
    input  wire logic [15:0]       pktEtype,
    output logic                   verdValid,
    output logic                   verdForward,
    output logic                   verdDrop,
    output logic                   verdHit,
    output logic [$clog2(NENT)-1:0] verdIndex,
    output logic [NPORTS-1:0]      portDisabled,
    output logic                   irq
);
    import pac_pkg::*;
    localparam int IW = $clog2(NENT);
    localparam int AW = IW + 4;

    // Every check in this module samples on ref_clk and stays quiet while reset stands.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // True when every bit not ignored by the mask agrees.
    function automatic logic maskEq(input logic [47:0] a, input logic [47:0] b,
                                    input logic [47:0] m);
        maskEq = ((a ^ b) & ~m) == 48'h0000_0000_0000;
    endfunction

    pac_word_t        entryMem [NENT*`PAC_ENT_WORDS];
    pac_state_e       state_r;
    logic [IW-1:0]    idx_r;
    logic             bound_r;
    logic [`PAC_ST_W-1:0] status_r;
    logic [`PAC_ST_W-1:0] mask_r;
    logic [PW-1:0]    port_r;
    logic             isIp_r;
    logic [7:0]       proto_r;
    logic [5:0]       flags_r;
    logic [15:0]      sport_r, dport_r, etype_r;
    logic [31:0]      sip_r, dip_r;
    logic [5:0]       dscp_r;
    logic [47:0]      smac_r, dmac_r;
    logic [11:0]      vlan_r;
    logic             pready_r;
    logic             pslverr_r;
    logic             verdValid_r;
    logic             verdForward_r;
    logic             verdDrop_r;
    logic             verdHit_r, pktReady_r, irq_r;
    logic [31:0]      prdata_r;
    logic [IW-1:0]    verdIndex_r;
    logic [NPORTS-1:0] portDis_r;

    // APB decode; a transfer completes on the edge where our registered ready is high.
    wire        apbDone  = psel & penable & pready_r;
    wire        apbWr    = apbDone & pwrite;
    wire        apbRd    = apbDone & ~pwrite;
    wire        entSel   = paddr[11:10] == `PAC_ENT_REGION;
    wire [3:0]  entNum   = paddr[9:6];
    wire        entOk    = entSel & ({28'h0, entNum} < NENT) & (paddr[5:2] < 4'hA);
    wire [AW-1:0] entAddr = {entNum[IW-1:0], paddr[5:2]};
    wire        isCtrl   = paddr == `PAC_OFF_CTRL;
    wire        isStat   = paddr == `PAC_OFF_STATUS;
    wire        isMask   = paddr == `PAC_OFF_MASK;
    wire        isPdis   = paddr == `PAC_OFF_PORTDIS;
    wire        isState  = paddr == `PAC_OFF_STATE;
    wire        mapped   = entOk | isCtrl | isStat | isMask | isPdis | isState;
    wire        entWrOk  = apbWr & entOk & ~bound_r;
    wire        statRdClr = apbRd & isStat;
    wire [31:0] rdMux    = entOk   ? entryMem[entAddr] :
                           isCtrl  ? {31'h0, bound_r} :
                           isStat  ? {29'h0, status_r} :
                           isMask  ? {29'h0, mask_r} :
                           isPdis  ? {{(32-NPORTS){1'b0}}, portDis_r} :
                           isState ? {{(32-IW-2){1'b0}}, idx_r, state_r} : `PAC_RST_ZERO;

    // Words of the entry under test this cycle.
    wire [31:0] w0 = entryMem[{idx_r, 4'h0}];
    wire [31:0] w1 = entryMem[{idx_r, 4'h1}];
    wire [31:0] w2 = entryMem[{idx_r, 4'h2}];
    wire [31:0] w3 = entryMem[{idx_r, 4'h3}];
    wire [31:0] w4 = entryMem[{idx_r, 4'h4}];
    wire [31:0] w5 = entryMem[{idx_r, 4'h5}];
    wire [31:0] w6 = entryMem[{idx_r, 4'h6}];
    wire [31:0] w7 = entryMem[{idx_r, 4'h7}];
    wire [31:0] w8 = entryMem[{idx_r, 4'h8}];
    wire [31:0] w9 = entryMem[{idx_r, 4'h9}];

    // IP criteria; a disabled criterion is simply true.
    wire        protoOk = ~w0[`PAC_F_PROTOEN] | (proto_r == w0[`PAC_F_PROTO]);
    wire        tcpOk   = ((flags_r ^ w1[`PAC_F_TCPVAL]) & w1[`PAC_F_TCPCARE]) == 6'h00;
    wire        l4Proto = w0[`PAC_F_PROTOEN] & ((w0[`PAC_F_PROTO] == `PAC_PROTO_TCP) |
                          (w0[`PAC_F_PROTO] == `PAC_PROTO_UDP));
    wire        sportOk = ~(l4Proto & w0[`PAC_F_SPORTEN]) | (sport_r == w2[`PAC_F_LO]);
    wire        dportOk = ~(l4Proto & w0[`PAC_F_DPORTEN]) | (dport_r == w2[`PAC_F_HI]);
    wire        sipOk   = maskEq({16'h0, sip_r}, {16'h0, w3}, {16'hFFFF, w4});
    wire        dipOk   = maskEq({16'h0, dip_r}, {16'h0, w5}, {16'hFFFF, w6});
    wire [1:0]  qsel    = w0[`PAC_F_QOSSEL];
    // The selector holds one code, so DSCP and precedence can never both be active.
    wire        qosOk   = (qsel == `PAC_QOS_DSCP) ? (dscp_r == w0[`PAC_F_DSCP]) :
                          (qsel == `PAC_QOS_PREC) ? (dscp_r[5:3] == w0[`PAC_F_PREC]) :
                          1'b1;
    wire        ipHit   = isIp_r & protoOk & tcpOk & sportOk & dportOk & sipOk & dipOk & qosOk;

    // Layer-2 criteria.
    wire        smacOk  = maskEq(smac_r, {w8[`PAC_F_LO], w3}, {w8[`PAC_F_HI], w4});
    wire        dmacOk  = maskEq(dmac_r, {w9[`PAC_F_LO], w5}, {w9[`PAC_F_HI], w6});
    wire [11:0] cfgVlan = w1[`PAC_F_VLAN];
    wire        vlanCfg = (cfgVlan >= `PAC_VLAN_MIN) & (cfgVlan <= `PAC_VLAN_MAX);
    // An out-of-range VLAN value never matches rather than widening the entry.
    wire        vlanOk  = ~w0[`PAC_F_VLANEN] | (vlanCfg & (vlan_r == cfgVlan));
    wire        etypeOk = ~w0[`PAC_F_ETYPEEN] | (etype_r == w7[`PAC_F_LO]);
    wire        l2Hit   = smacOk & dmacOk & vlanOk & etypeOk;

    wire        inWalk  = state_r == PAC_WALK;
    wire        hit     = w0[`PAC_F_VALID] & (w0[`PAC_F_L2] ? l2Hit : ipHit);
    wire [1:0]  act     = w0[`PAC_F_ACTION];
    wire        lastIdx = {{(32-IW){1'b0}}, idx_r} == NENT - 1;
    wire        finish  = inWalk & (hit | lastIdx | ~bound_r);
    wire        take    = pktValid & pktReady_r;
    wire        shutEv  = inWalk & hit & bound_r & (act == `PAC_ACT_SHUT);
    wire        denyEv  = inWalk & hit & bound_r & (act != `PAC_ACT_PERMIT) & ~shutEv;
    wire        missEv  = inWalk & ~hit & lastIdx & bound_r;
    wire [`PAC_ST_W-1:0] evVec = {missEv, shutEv, denyEv};

    // Sequencer: take a header, walk entries, stop at the first hit.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= PAC_IDLE;
            idx_r   <= '0;
        end else begin
            case (state_r)
                PAC_IDLE: begin
                    idx_r <= '0;
                    if (take) state_r <= PAC_WALK;
                end
                PAC_WALK: begin
                    if (finish) state_r <= PAC_DONE;
                    else idx_r <= idx_r + 1'b1;
                end
                PAC_DONE: state_r <= PAC_IDLE;
                default:  state_r <= PAC_IDLE;
            endcase
        end
    end

    // Header capture; held for the whole walk so a changing source cannot split a verdict.
    always_ff @(posedge ref_clk) begin
        if (take) begin
            port_r  <= pktPort;
            isIp_r  <= pktIsIp;
            proto_r <= pktProto;
            flags_r <= pktTcpFlags;
            sport_r <= pktSrcPort;
            dport_r <= pktDstPort;
            sip_r   <= pktSrcIp;
            dip_r   <= pktDstIp;
            dscp_r  <= pktDscp;
            smac_r  <= pktSrcMac;
            dmac_r  <= pktDstMac;
            vlan_r  <= pktVlan;
            etype_r <= pktEtype;
        end
    end

    // Verdict; an unbound list passes everything.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {verdValid_r, verdForward_r, verdDrop_r, verdHit_r} <= 4'h0;
            verdIndex_r <= '0;
            pktReady_r  <= 1'b0;
        end else begin
            verdValid_r   <= finish;
            pktReady_r    <= (state_r == PAC_IDLE) & ~take & ~pktReady_r |
                             (state_r == PAC_IDLE) & pktReady_r & ~take;
            if (finish) begin
                verdHit_r     <= hit & bound_r;
                verdIndex_r   <= idx_r;
                verdForward_r <= ~bound_r | (hit & (act == `PAC_ACT_PERMIT));
                verdDrop_r    <= bound_r & (~hit | (act != `PAC_ACT_PERMIT));
            end
        end
    end

    // Port disables: shutdown sets, only a software write of one clears; set wins.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) portDis_r <= '0;
        else portDis_r <= (portDis_r & ~((apbWr & isPdis) ? pwdata[NPORTS-1:0] : '0)) |
                          (shutEv ? (NPORTS'(1) << port_r) : '0);
    end

    // Sticky events; a read clears only the bits it returned, so an event that lands
    // between the data sample and the clearing edge is kept for the next read.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_r <= '0;
            mask_r   <= '0;
            bound_r  <= 1'b0;
            irq_r    <= 1'b0;
        end else begin
            status_r <= (status_r & ~(statRdClr ? prdata_r[`PAC_ST_W-1:0] : '0)) | evVec;
            irq_r    <= |(status_r & mask_r);
            if (apbWr & isMask) mask_r <= pwdata[`PAC_ST_W-1:0];
            if (apbWr & isCtrl) bound_r <= pwdata[0];
        end
    end

    // Entry storage; cleared at reset so no entry is valid until loaded.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NENT*`PAC_ENT_WORDS; i++) entryMem[i] <= `PAC_RST_ZERO;
        end else if (entWrOk) begin
            entryMem[entAddr] <= pwdata;
        end
    end

    // APB answer: one wait state so every bus output comes from a flop.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= `PAC_RST_ZERO;
        end else begin
            pready_r  <= psel & penable & ~pready_r;
            pslverr_r <= psel & penable & ~pready_r & ~mapped;
            prdata_r  <= (psel & penable & ~pready_r & ~pwrite) ? rdMux : `PAC_RST_ZERO;
        end
    end

    assign prdata       = prdata_r;
    assign pready       = pready_r;
    assign pslverr      = pslverr_r;
    assign pktReady     = pktReady_r;
    assign verdValid    = verdValid_r;
    assign verdForward  = verdForward_r;
    assign verdDrop     = verdDrop_r;
    assign verdHit      = verdHit_r;
    assign verdIndex    = verdIndex_r;
    assign portDisabled = portDis_r;
    assign irq          = irq_r;

    a_walk_order: assert property (inWalk && !finish
        |=> inWalk && idx_r == $past(idx_r) + 1'b1)
        else $error("entry walk skipped or repeated an index");
    a_first_hit: assert property (inWalk && hit
        |=> verdValid_r && verdIndex_r == $past(idx_r) ##1 !inWalk)
        else $error("walk continued past first hit");
    a_permit_pass: assert property (inWalk && hit && bound_r && act == `PAC_ACT_PERMIT
        |=> verdForward_r && !verdDrop_r)
        else $error("permit hit not forwarded");
    a_deny_drop: assert property (denyEv
        |=> verdDrop_r && !verdForward_r && status_r[`PAC_ST_DENY])
        else $error("deny hit not dropped");
    a_shut_port: assert property (shutEv
        |=> verdDrop_r && portDis_r[$past(port_r)])
        else $error("shutdown hit left port enabled");
    a_port_stays: assert property (portDis_r[0] && !(apbWr && isPdis)
        |=> portDis_r[0])
        else $error("disabled port re-enabled without software");
    a_proto_any: assert property (!w0[`PAC_F_PROTOEN]
        |-> protoOk)
        else $error("unconfigured protocol blocked a match");
    a_tcp_care: assert property (w1[`PAC_F_TCPCARE] == 6'h00
        |-> tcpOk)
        else $error("ignored TCP flags blocked a match");
    a_l4_ignore: assert property (!l4Proto
        |-> sportOk && dportOk)
        else $error("layer-4 ports compared for non TCP/UDP entry");
    a_sip_wild: assert property (w4 == 32'hFFFF_FFFF
        |-> sipOk)
        else $error("all-ones source mask did not match");
    a_sip_care: assert property (w4 == 32'h0000_0000 && sip_r != w3
        |-> !sipOk)
        else $error("unmasked source address bits were not compared");
    a_dip_wild: assert property (w6 == 32'hFFFF_FFFF
        |-> dipOk)
        else $error("all-ones destination mask did not match");
    a_prec_sel: assert property (qsel == `PAC_QOS_PREC
        |-> qosOk == (dscp_r[5:3] == w0[`PAC_F_PREC]))
        else $error("precedence entry compared the wrong field");
    a_bound_lock: assert property (bound_r && apbWr && entOk
        |=> entryMem[$past(entAddr)] == $past(entryMem[entAddr]))
        else $error("entry changed while list bound");
    a_dmac_wild: assert property ({w9[`PAC_F_HI], w6} == 48'hFFFF_FFFF_FFFF
        |-> dmacOk)
        else $error("all-ones destination MAC mask did not match");
    a_vlan_eq: assert property (w0[`PAC_F_VLANEN] && vlan_r != cfgVlan
        |-> !vlanOk)
        else $error("VLAN criterion matched a different identifier");
    a_etype_eq: assert property (w0[`PAC_F_ETYPEEN] && etype_r != w7[`PAC_F_LO]
        |-> !etypeOk)
        else $error("Ethernet type criterion matched a different value");
    a_miss_drop: assert property (missEv
        |=> verdDrop_r && !verdHit_r ##1 status_r[`PAC_ST_MISS])
        else $error("unmatched packet not dropped on bound list");
    a_etype_any: assert property (!w0[`PAC_F_ETYPEEN]
        |-> etypeOk)
        else $error("unconfigured Ethernet type blocked a match");
endmodule // pac_classifier

// file: inc/pac_consts.svh
/*
 * Offsets, field positions, reset values and encodings of the packet rule_list classifier.
 * It assumes that it is included by its bare name wherever these names are needed.
 */
`ifndef PAC_CONSTS_SVH
`define PAC_CONSTS_SVH

// Register byte offsets within the 4 KB window.
`define PAC_OFF_CTRL    12'h000
`define PAC_OFF_STATUS  12'h004
`define PAC_OFF_MASK    12'h008
`define PAC_OFF_PORTDIS 12'h00C
`define PAC_OFF_STATE   12'h010
`define PAC_ENT_REGION  2'h1
`define PAC_ENT_WORDS   16

// Entry word 0 fields.
`define PAC_F_VALID   0
`define PAC_F_ACTION  2:1
`define PAC_F_L2      3
`define PAC_F_PROTOEN 4
`define PAC_F_PROTO   12:5
`define PAC_F_QOSSEL  14:13
`define PAC_F_DSCP    20:15
`define PAC_F_PREC    23:21
`define PAC_F_VLANEN  24
`define PAC_F_ETYPEEN 25
`define PAC_F_SPORTEN 26
`define PAC_F_DPORTEN 27
// Entry word 1 fields.
`define PAC_F_TCPCARE 5:0
`define PAC_F_TCPVAL  13:8
`define PAC_F_VLAN    27:16
// Entry words 2, 7, 8 and 9: low and high halves.
`define PAC_F_LO      15:0
`define PAC_F_HI      31:16

// Encodings and limits.
`define PAC_ACT_PERMIT 2'h0
`define PAC_ACT_DENY   2'h1
`define PAC_ACT_SHUT   2'h2
`define PAC_QOS_DSCP   2'h1
`define PAC_QOS_PREC   2'h2
`define PAC_PROTO_TCP  8'h06
`define PAC_PROTO_UDP  8'h11
`define PAC_VLAN_MIN   12'h002
`define PAC_VLAN_MAX   12'hFFE

// Status bits and reset values.
`define PAC_ST_DENY  0
`define PAC_ST_SHUT  1
`define PAC_ST_MISS  2
`define PAC_ST_W     3
`define PAC_RST_ZERO 32'h0000_0000

`endif

// file: inc/pac_pkg.sv
/*
 * Types of the packet rule_list classifier.
 * It assumes pac_consts.svh is available to files that need the numbers.
 */
package pac_pkg;
    typedef enum logic [1:0] {PAC_IDLE, PAC_WALK, PAC_DONE} pac_state_e;
    typedef logic [31:0] pac_word_t;
endpackage

// file: bench/pac_hdr_src.sv
/*
 * Forwarding-pipeline model that offers parsed headers to the classifier.
 * It assumes the classifier shares ref_clk and takes a header at pktValid and pktReady.
 */
`timescale 1ns/1ps
module pac_hdr_src #(
    parameter int PW = 3
) (
    input  wire logic          ref_clk,
    output logic               pktValid,
    input  wire logic          pktReady,
    output logic [PW-1:0]      pktPort,
    output logic               pktIsIp,
    output logic [7:0]         pktProto,
    output logic [5:0]         pktTcpFlags,
    output logic [15:0]        pktSrcPort,
    output logic [15:0]        pktDstPort,
    output logic [31:0]        pktSrcIp,
    output logic [31:0]        pktDstIp,
    output logic [5:0]         pktDscp,
    output logic [47:0]        pktSrcMac,
    output logic [47:0]        pktDstMac,
    output logic [11:0]        pktVlan,
    output logic [15:0]        pktEtype
);
    logic [PW+240:0] hdr;

    // Fields come from one packed image; once taken it shows its inverse, never stale data.
    assign {pktPort, pktIsIp, pktProto, pktTcpFlags, pktSrcPort, pktDstPort, pktSrcIp,
            pktDstIp, pktDscp, pktSrcMac, pktDstMac, pktVlan, pktEtype} = hdr;

    // Nothing is offered until the bench asks.
    initial begin
        pktValid = 1'b0;
        hdr = '0;
    end

    // Offers one header and holds it until the edge at which the classifier takes it.
    task automatic send(input logic [PW+240:0] h, output int n);
        @(posedge ref_clk);
        pktValid <= 1'b1;
        hdr <= h;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pktReady !== 1'b1 && n < 50);
        pktValid <= 1'b0;
        hdr <= ~h;
    endtask
endmodule // pac_hdr_src

// file: bench/packet_access_list_classifier_tb_top.sv
/*
 * Self-checking bench of the classifier: registers over APB, verdicts, port shutdown, irq.
 * It assumes the pipeline model pac_hdr_src and a 200 MHz ref_clk.
 */
`timescale 1ns/1ps
`include "pac_consts.svh"
module packet_access_list_classifier_tb_top;
    import pac_pkg::*;
    localparam int NENT = 8;
    localparam int PW   = 3;
    logic                    ref_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0]             paddr;
    pac_word_t               pwdata;
    logic [31:0]             prdata, q;
    logic                    pktValid, pktReady, pktIsIp, verdValid, verdForward, verdDrop;
    logic                    verdHit, e;
    logic [PW-1:0]           pktPort;
    logic [7:0]              pktProto, portDisabled;
    logic [5:0]              pktTcpFlags, pktDscp;
    logic [15:0]             pktSrcPort, pktDstPort, pktEtype;
    logic [31:0]             pktSrcIp, pktDstIp;
    logic [47:0]             pktSrcMac, pktDstMac;
    logic [11:0]             pktVlan;
    logic [$clog2(NENT)-1:0] verdIndex;
    int                      n_fail, cmp_count, cycles;

    pac_classifier #(.NENT(NENT), .NPORTS(8), .PW(PW)) pac_classifier_i (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pktValid(pktValid), .pktReady(pktReady), .pktPort(pktPort), .pktIsIp(pktIsIp),
        .pktProto(pktProto), .pktTcpFlags(pktTcpFlags), .pktSrcPort(pktSrcPort),
        .pktDstPort(pktDstPort), .pktSrcIp(pktSrcIp), .pktDstIp(pktDstIp), .pktDscp(pktDscp),
        .pktSrcMac(pktSrcMac), .pktDstMac(pktDstMac), .pktVlan(pktVlan), .pktEtype(pktEtype),
        .verdValid(verdValid), .verdForward(verdForward), .verdDrop(verdDrop),
        .verdHit(verdHit), .verdIndex(verdIndex), .portDisabled(portDisabled), .irq(irq));

    pac_hdr_src #(.PW(PW)) pac_hdr_src_i (
        .ref_clk(ref_clk), .pktValid(pktValid), .pktReady(pktReady), .pktPort(pktPort),
        .pktIsIp(pktIsIp), .pktProto(pktProto), .pktTcpFlags(pktTcpFlags),
        .pktSrcPort(pktSrcPort), .pktDstPort(pktDstPort), .pktSrcIp(pktSrcIp),
        .pktDstIp(pktDstIp), .pktDscp(pktDscp), .pktSrcMac(pktSrcMac), .pktDstMac(pktDstMac),
        .pktVlan(pktVlan), .pktEtype(pktEtype));

    // The clock toggles every half period of 2.5 ns.
    initial ref_clk = 1'b0;
    always #2.5 ref_clk = ~ref_clk;

    // The whole run needs about 200 cycles, so 20000 can only mean a hang.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            $display("mismatch run length expected finish seen hang");
            conclude();
        end
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        chk("pready", 32'h0000_0001, {31'h0, pready});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x, input logic r);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, x, q);
        chk({nm, " error"}, {31'h0, r}, {31'h0, e});
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk("write error", 32'h0000_0000, {31'h0, e});
    endtask

    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    // Builds a header; destination port, source address and destination MAC stay fixed.
    function automatic logic [PW+240:0] mk(logic [PW-1:0] p, logic ip, logic [7:0] pr,
        logic [5:0] fl, logic [31:0] dip, logic [47:0] sm, logic [11:0] vl, logic [15:0] et);
        return {p, ip, pr, fl, 16'h0050, 16'h1234, 32'hC0A8_0001, dip, 6'h2E, sm,
                48'h0200_0000_0001, vl, et};
    endfunction

    // Sends a header, then checks the verdict and its latency counted from the taking edge.
    task automatic pkt(input string nm, input logic [PW+240:0] h, input logic [2:0] v,
                       input int idx, input int lat);
        int n;
        int l;
        pac_hdr_src_i.send(h, n);
        l = 0;
        do begin
            @(posedge ref_clk);
            #1;
            l++;
        end while (verdValid !== 1'b1 && l < 40);
        chk({nm, " latency"}, lat, l);
        chk({nm, " verdict"}, {29'h0, v}, {29'h0, verdForward, verdDrop, verdHit});
        if (v[0]) chk({nm, " index"}, idx, 32'(verdIndex));
    endtask

    task automatic t_regs();
        rd("ctrl", `PAC_OFF_CTRL, `PAC_RST_ZERO, 1'b0);
        rd("status", `PAC_OFF_STATUS, `PAC_RST_ZERO, 1'b0);
        rd("mask", `PAC_OFF_MASK, `PAC_RST_ZERO, 1'b0);
        rd("portdis", `PAC_OFF_PORTDIS, `PAC_RST_ZERO, 1'b0);
        rd("state", `PAC_OFF_STATE, `PAC_RST_ZERO, 1'b0);
        rd("hole", 12'h020, 32'h0000_0000, 1'b1);
        rd("word ten", 12'h428, 32'h0000_0000, 1'b1);
        rd("entry past end", 12'h600, 32'h0000_0000, 1'b1);
        $display("test registers done");
    endtask

    // Entry table: L2 deny at 0, TCP shutdown at 1, IP permit on DSCP at 2, UDP permit on precedence 5 at 3.
    task automatic t_load();
        logic [43:0] tb [19] = '{
            {4'h0, 8'h00, 32'h0300_000B}, {4'h0, 8'h04, 32'h0005_0000},
            {4'h0, 8'h0C, 32'h1122_3344}, {4'h0, 8'h10, 32'h0000_00FF},
            {4'h0, 8'h18, 32'hFFFF_FFFF}, {4'h0, 8'h1C, 32'h0000_88B5},
            {4'h0, 8'h24, 32'hFFFF_0000}, {4'h1, 8'h00, 32'h0400_00D5},
            {4'h1, 8'h04, 32'h0000_0212}, {4'h1, 8'h08, 32'h0000_0050},
            {4'h1, 8'h10, 32'hFFFF_FFFF}, {4'h1, 8'h18, 32'hFFFF_FFFF},
            {4'h2, 8'h00, 32'h0017_2001}, {4'h2, 8'h10, 32'hFFFF_FFFF},
            {4'h2, 8'h14, 32'h0A01_0200}, {4'h2, 8'h18, 32'h0000_00FF},
            {4'h3, 8'h00, 32'h00A0_4231}, {4'h3, 8'h10, 32'hFFFF_FFFF},
            {4'h3, 8'h18, 32'hFFFF_FFFF}};
        foreach (tb[i])
            wr(12'h400 + {2'h0, tb[i][43:40], 6'h0} + {4'h0, tb[i][39:32]}, tb[i][31:0]);
        wr(`PAC_OFF_MASK, 32'h0000_0002);
        wr(`PAC_OFF_CTRL, 32'h0000_0001);
        rd("bound", `PAC_OFF_CTRL, 32'h0000_0001, 1'b0);
        $display("test load done");
    endtask

    task automatic t_verdicts();
        logic [PW+240:0] l2;
        l2 = mk(3'h1, 1'b0, 8'h00, 6'h00, 32'h0, 48'h0000_1122_33AA, 12'h005, 16'h88B5);
        pkt("unbound", l2, 3'b100, 0, 1);
        t_load();
        pkt("l2 deny", l2, 3'b011, 0, 1);
        settle();
        chk("masked irq", 32'h0, {31'h0, irq});
        pkt("syn ack", mk(3'h3, 1'b1, 8'h06, 6'h12, 32'h0A01_0205, 48'hAABB_CCDD, 12'h6,
            16'h0800), 3'b101, 2, 3);
        pkt("udp", mk(3'h3, 1'b1, 8'h11, 6'h02, 32'h0A01_0207, 48'hAABB_CCDD, 12'h6,
            16'h0800), 3'b101, 2, 3);
        pkt("syn", mk(3'h3, 1'b1, 8'h06, 6'h02, 32'h0A01_0205, 48'hAABB_CCDD, 12'h6,
            16'h0800), 3'b011, 1, 2);
        settle();
        chk("port off", 32'h08, {24'h0, portDisabled});
        chk("irq up", 32'h1, {31'h0, irq});
        rd("status", `PAC_OFF_STATUS, 32'h0000_0003, 1'b0);
        settle();
        chk("irq down", 32'h0, {31'h0, irq});
        rd("status clear", `PAC_OFF_STATUS, 32'h0000_0000, 1'b0);
        pkt("precedence", mk(3'h3, 1'b1, 8'h11, 6'h00, 32'h0A01_0305, 48'hAABB_CCDD, 12'h6,
            16'h0800), 3'b101, 3, 4);
        pkt("miss", mk(3'h3, 1'b1, 8'h06, 6'h12, 32'h0A01_0305, 48'hAABB_CCDD, 12'h6,
            16'h0800), 3'b010, 0, NENT);
        rd("miss status", `PAC_OFF_STATUS, 32'h0000_0004, 1'b0);
        wr(12'h400, 32'h0300_0009);
        pkt("locked", l2, 3'b011, 0, 1);
        chk("port held", 32'h08, {24'h0, portDisabled});
        wr(`PAC_OFF_PORTDIS, 32'h0000_0008);
        settle();
        chk("port on", 32'h00, {24'h0, portDisabled});
        $display("test verdicts done");
    endtask

    // Reset stands for six cycles with every input quiet.
    initial begin
        n_fail = 0;
        cmp_count = 0;
        cycles = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_verdicts();
        conclude();
    end
endmodule // packet_access_list_classifier_tb_top
